/* File: hdl/vpd_eeprom_access.sv */
/*
   product data access engine: moves four bytes between the product data
   register and a 256-byte serial EEPROM over I2C.
   assumes software holds the shared lock and keeps address and register
   stable while a transfer runs; SCL and SDA are open drain with pull-ups.
*/
// How it works
// R1: after reset the select field is zero, the register-load EEPROM.
// R2: select zero adds 64 to every address before the EEPROM sees it.
// R3: select zero reaches 0x00-0xBF; first 64 read-only, next 128 writable.
// R4: other selects reach all 256 bytes untranslated; first 64 read-only.
// R5: software takes the shared lock before any access.
// R6: address is eight bits and double-word aligned.
// R7: a read fetches four bytes, first byte into bits 7:0.
// R8: software starts a read writing the address with flag zero.
// R9: the flag goes to one once four read bytes are stored.
// R10: software leaves the registers alone during a read.
// R11: a write stores four bytes, bits 7:0 at the given address.
// R12: software loads data then writes address with flag one.
// R13: the flag clears once the write is stored.
// R14: a write to the read-only region is skipped and the flag cleared.
// R15: software leaves the registers alone during a write.
// R16: no transfer starts unless enabled and an EEPROM is present; the flag is still cleared.
// R17: transfers are random reads and page writes with an eight-bit address.
`timescale 1ns/100ps
module vpd_eeprom_access (
   input wire logic CLOCK,  // 10 MHz clock
   input wire logic RSTN,   // async reset, active low
   input wire logic PRODUCT_DATA_FEATURE_ENABLE, // feature enable
   input wire logic EEPROM_PRESENT, // external EEPROM fitted
   input wire logic [2:0] EEPROM_SELECT_FIELD, // chip select
   input wire logic ADDR_WRITE, // pulse: address and flag written
   input wire logic [7:0] PRODUCT_DATA_ADDRESS_FIELD, // requested address
   input wire logic FLAG_IN,    // flag written with address
   input wire logic DATA_WRITE, // pulse: data register written
   input wire logic [31:0] DATA_IN, // data register write value
   output logic [31:0] PRODUCT_DATA_REGISTER, // data register
   output logic FLAG,       // completion flag
   output logic BUSY,       // transfer in progress
   input wire logic SCL_IN, // clock pin in
   output logic SCL_OUT,    // clock pin out, always low
   output logic SCL_OE,     // clock pin drive
   input wire logic SDA_IN, // data pin in
   output logic SDA_OUT,    // data pin out, always low
   output logic SDA_OE      // data pin drive
);
   logic [1:0] pins;
   logic scl_s;
   logic sda_s;
   vpd_sync #(.W(2)) u_sync (
      .clk(CLOCK),
      .rst_n(RSTN),
      .d({SCL_IN, SDA_IN}),
      .q(pins)
   );
   assign scl_s = pins[1];
   assign sda_s = pins[0];

   function automatic logic [7:0] eeprom_addr(input logic [7:0] a, input logic [2:0] cs);
      eeprom_addr = (cs == vpd_pkg::CS_DEFAULT) ? a + vpd_pkg::SETUP_OFFSET : a; // R2 R4
   endfunction : eeprom_addr

   vpd_pkg::vpd_state_t state_reg, state_next;
   logic [31:0] data_reg, data_next;
   logic flag_reg, flag_next;
   logic wr_reg, wr_next;
   logic [7:0] addr_reg, addr_next;
   logic [7:0] sh_reg, sh_next;
   logic [2:0] bit_reg, bit_next;
   logic [1:0] phase_reg, phase_next;
   logic [1:0] idx_reg, idx_next;
   logic [1:0] hdr_reg, hdr_next;
   logic [7:0] tick_reg, tick_next;
   logic scl_lo_reg, scl_lo_next;
   logic sda_lo_reg, sda_lo_next;
   logic [2:0] cs_reg, cs_next;
   logic tick;
   logic in_range;
   logic writable;
   logic scl_held;

   if (vpd_pkg::HALF_BIT_CYC > 256) begin : g_bad_tick
      $error("quarter bit count exceeds the tick counter");
   end

   assign tick = (tick_reg == 8'(vpd_pkg::HALF_BIT_CYC - 1));
   // clock released but still low: a slave is stretching it
   assign scl_held = !scl_lo_reg && !scl_s;
   always_comb begin
      in_range = (EEPROM_SELECT_FIELD != vpd_pkg::CS_DEFAULT) // R3 R4 R6
         || (PRODUCT_DATA_ADDRESS_FIELD <= vpd_pkg::CS0_LIMIT);
      writable = in_range && (PRODUCT_DATA_ADDRESS_FIELD > vpd_pkg::RO_LIMIT); // R14
   end

   always_comb begin
      state_next = state_reg;
      data_next = data_reg;
      flag_next = flag_reg;
      wr_next = wr_reg;
      addr_next = addr_reg;
      sh_next = sh_reg;
      bit_next = bit_reg;
      phase_next = phase_reg;
      idx_next = idx_reg;
      hdr_next = hdr_reg;
      tick_next = tick ? 8'h00 : (scl_held ? tick_reg : tick_reg + 8'h01);
      scl_lo_next = scl_lo_reg;
      sda_lo_next = sda_lo_reg;
      cs_next = cs_reg;
      if (state_reg == vpd_pkg::VPD_IDLE) begin
         tick_next = 8'h00;
         if (DATA_WRITE) begin
            data_next = DATA_IN;
         end
         if (ADDR_WRITE) begin
            flag_next = FLAG_IN;
            if (PRODUCT_DATA_FEATURE_ENABLE && EEPROM_PRESENT && in_range // R16
                  && (!FLAG_IN || writable)) begin
               wr_next = FLAG_IN;
               cs_next = EEPROM_SELECT_FIELD;
               addr_next = eeprom_addr({PRODUCT_DATA_ADDRESS_FIELD[7:2], 2'h0},
                  EEPROM_SELECT_FIELD); // R2 R6
               idx_next = 2'h0;
               hdr_next = 2'h0;
               phase_next = 2'h0;
               state_next = vpd_pkg::VPD_START;
            end else if (FLAG_IN) begin
               flag_next = 1'b0; // R14
            end
         end
      end else if (tick) begin
         phase_next = phase_reg + 2'h1;
         case (state_reg)
            vpd_pkg::VPD_START, vpd_pkg::VPD_RSTART: begin
               case (phase_reg)
                  2'h0: sda_lo_next = 1'b0;
                  2'h1: scl_lo_next = 1'b0;
                  2'h2: sda_lo_next = 1'b1; // R17
                  default: begin
                     scl_lo_next = 1'b1;
                     bit_next = 3'h7;
                     sh_next = {vpd_pkg::DEV_TYPE, cs_reg,
                        state_reg == vpd_pkg::VPD_RSTART};
                     state_next = vpd_pkg::VPD_SEND;
                  end
               endcase
            end
            vpd_pkg::VPD_SEND, vpd_pkg::VPD_RECV: begin
               case (phase_reg)
                  2'h0: sda_lo_next = (state_reg == vpd_pkg::VPD_SEND) && !sh_reg[bit_reg];
                  2'h1: scl_lo_next = 1'b0;
                  2'h2: if (state_reg == vpd_pkg::VPD_RECV) sh_next[bit_reg] = sda_s;
                  default: begin
                     scl_lo_next = 1'b1;
                     bit_next = bit_reg - 3'h1;
                     if (bit_reg == 3'h0) begin
                        state_next = (state_reg == vpd_pkg::VPD_SEND) ? vpd_pkg::VPD_ACK
                           : vpd_pkg::VPD_MACK;
                     end
                  end
               endcase
            end
            vpd_pkg::VPD_ACK: begin
               case (phase_reg)
                  2'h0: sda_lo_next = 1'b0;
                  2'h1: scl_lo_next = 1'b0;
                  2'h2: ;
                  default: begin
                     scl_lo_next = 1'b1;
                     bit_next = 3'h7;
                     if (hdr_reg == 2'h0) begin
                        hdr_next = 2'h1;
                        sh_next = addr_reg; // R17
                        state_next = vpd_pkg::VPD_SEND;
                     end else if (!wr_reg && hdr_reg == 2'h1) begin
                        hdr_next = 2'h2;
                        state_next = vpd_pkg::VPD_RSTART;
                     end else if (!wr_reg) begin
                        state_next = vpd_pkg::VPD_RECV;
                     end else if (hdr_reg == 2'h1) begin
                        hdr_next = 2'h2;
                        sh_next = data_reg[7:0]; // R11
                        state_next = vpd_pkg::VPD_SEND;
                     end else if (idx_reg == vpd_pkg::BYTES_LAST) begin
                        state_next = vpd_pkg::VPD_STOP;
                     end else begin
                        idx_next = idx_reg + 2'h1;
                        sh_next = data_reg[8*(idx_reg+2'h1) +: 8]; // R11
                        state_next = vpd_pkg::VPD_SEND;
                     end
                  end
               endcase
            end
            vpd_pkg::VPD_MACK: begin
               case (phase_reg)
                  2'h0: begin
                     sda_lo_next = (idx_reg != vpd_pkg::BYTES_LAST);
                     data_next[8*idx_reg +: 8] = sh_reg; // R7
                  end
                  2'h1: scl_lo_next = 1'b0;
                  2'h2: ;
                  default: begin
                     scl_lo_next = 1'b1;
                     bit_next = 3'h7;
                     idx_next = idx_reg + 2'h1;
                     state_next = (idx_reg == vpd_pkg::BYTES_LAST) ? vpd_pkg::VPD_STOP
                        : vpd_pkg::VPD_RECV;
                  end
               endcase
            end
            vpd_pkg::VPD_STOP: begin
               case (phase_reg)
                  2'h0: sda_lo_next = 1'b1;
                  2'h1: scl_lo_next = 1'b0;
                  2'h2: sda_lo_next = 1'b0;
                  default: state_next = vpd_pkg::VPD_DONE;
               endcase
            end
            vpd_pkg::VPD_DONE: begin
               flag_next = !wr_reg; // R9 R13
               state_next = vpd_pkg::VPD_IDLE;
            end
            default: state_next = vpd_pkg::VPD_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg <= vpd_pkg::VPD_IDLE;
         data_reg <= 32'h0000_0000;
         flag_reg <= 1'b0;
         wr_reg <= 1'b0;
         addr_reg <= 8'h00;
         sh_reg <= 8'h00;
         bit_reg <= 3'h0;
         phase_reg <= 2'h0;
         idx_reg <= 2'h0;
         hdr_reg <= 2'h0;
         tick_reg <= 8'h00;
         scl_lo_reg <= 1'b0;
         sda_lo_reg <= 1'b0;
         cs_reg <= vpd_pkg::CS_DEFAULT; // R1
      end else begin
         state_reg <= state_next;
         data_reg <= data_next;
         flag_reg <= flag_next;
         wr_reg <= wr_next;
         addr_reg <= addr_next;
         sh_reg <= sh_next;
         bit_reg <= bit_next;
         phase_reg <= phase_next;
         idx_reg <= idx_next;
         hdr_reg <= hdr_next;
         tick_reg <= tick_next;
         scl_lo_reg <= scl_lo_next;
         sda_lo_reg <= sda_lo_next;
         cs_reg <= cs_next;
      end
   end

   assign PRODUCT_DATA_REGISTER = data_reg;
   assign FLAG = flag_reg;
   assign BUSY = (state_reg != vpd_pkg::VPD_IDLE);
   assign SCL_OUT = 1'b0;
   assign SDA_OUT = 1'b0;
   assign SCL_OE = scl_lo_reg;
   assign SDA_OE = sda_lo_reg;
endmodule : vpd_eeprom_access

/* File: hdl/vpd_pkg.sv */
/*
   shared constants and carrier types for the product data access block.
   assumes a single 10 MHz clock domain and an I2C bus driven open drain.
*/
package vpd_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int I2C_HZ = 100_000;
   localparam int HALF_BIT_CYC = (CLK_HZ / I2C_HZ) / 4 > 0 ? (CLK_HZ / I2C_HZ) / 4 : 1;
   localparam logic [2:0] CS_DEFAULT = 3'h0;
   localparam logic [7:0] SETUP_OFFSET = 8'h40;
   localparam logic [7:0] CS0_LIMIT = 8'hBF;
   localparam logic [7:0] RO_LIMIT = 8'h3F;
   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam logic [1:0] BYTES_LAST = 2'h3;

   typedef struct packed {
      logic [7:0] addr;
      logic flag;
   } vpd_req_t;

   typedef enum logic [3:0] {
      VPD_IDLE = 4'h0, VPD_START = 4'h1, VPD_SEND = 4'h3, VPD_ACK = 4'h2,
      VPD_RSTART = 4'h6, VPD_RECV = 4'h7, VPD_MACK = 4'h5, VPD_STOP = 4'h4,
      VPD_DONE = 4'hC
   } vpd_state_t;
endpackage : vpd_pkg

/* File: hdl/vpd_sync.sv */
/*
   two flip-flop synchroniser for a bundle of pin inputs.
   assumes the inputs are asynchronous to CLOCK.
*/
`timescale 1ns/100ps
module vpd_sync #(
   parameter int W = 2
) (
   input wire logic clk,   // clock
   input wire logic rst_n, // async reset
   input wire logic [W-1:0] d, // raw pins
   output logic [W-1:0] q  // synchronised
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   if (W < 1) begin : g_bad_width
      $error("synchroniser width must be at least one");
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end
   assign q = sync_reg;
endmodule : vpd_sync

/* File: test/vpd_eeprom_model.sv */
/*
   behavioural serial EEPROM answering random reads and page writes.
   assumes open-drain lines with pull-ups; never stretches the clock.
*/
`timescale 1ns/100ps
module vpd_eeprom_model #(
   parameter logic [2:0] SEL = 3'h0,
   parameter logic [7:0] SEED = 8'h00
) (
   input wire logic scl, // clock line
   input wire logic sda, // data line
   output logic sda_oe   // high pulls data low
);
   logic [7:0] mem [256];
   logic [7:0] sh;
   logic [7:0] ptr;
   logic act = 1'b0;
   logic rd = 1'b0;
   logic first = 1'b0;
   logic need_addr = 1'b0;
   int cnt = 0;
   initial begin
      sda_oe = 1'b0;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ SEED;
   end
   always @(negedge sda) if (scl === 1'b1) begin
      act = 1'b1;
      rd = 1'b0;
      first = 1'b1;
      cnt = 0;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      act = 1'b0;
      sda_oe = 1'b0;
   end
   always @(posedge scl) if (act) begin
      if (!rd && cnt < 8) sh = {sh[6:0], sda};
      if (rd && cnt == 8 && sda) act = 1'b0;
      cnt++;
   end
   always @(negedge scl) if (act) begin
      if (cnt == 9) begin
         cnt = 0;
         if (rd) begin
            sh = mem[ptr];
            ptr++;
         end
         sda_oe = rd && !sh[7];
      end else if (rd) sda_oe = cnt < 8 ? ~sh[7 - cnt] : 1'b0;
      else if (cnt == 8) begin
         if (first) begin
            first = 1'b0;
            rd = sh[0];
            need_addr = ~sh[0];
            act = (sh[7:1] == {4'hA, SEL});
         end else if (need_addr) begin
            ptr = sh;
            need_addr = 1'b0;
         end else begin
            mem[ptr] = sh;
            ptr++;
         end
         sda_oe = act;
      end
   end
endmodule : vpd_eeprom_model

/* File: test/vpd_eeprom_access_props.sv */
/*
   assertions on the product data access block's ports.
   assumes it is bound to the top module with port names matching.
*/
`timescale 1ns/100ps
module vpd_eeprom_access_props (
   input wire logic CLOCK, // clock
   input wire logic RSTN, // async reset
   input wire logic PRODUCT_DATA_FEATURE_ENABLE, // enable
   input wire logic EEPROM_PRESENT, // fitted
   input wire logic [2:0] EEPROM_SELECT_FIELD, // chip select
   input wire logic ADDR_WRITE, // request
   input wire logic [7:0] PRODUCT_DATA_ADDRESS_FIELD, // address
   input wire logic FLAG_IN, // direction
   input wire logic FLAG, // completion flag
   input wire logic BUSY, // in progress
   input wire logic SCL_OE, // clock drive
   input wire logic SDA_OE // data drive
);
   localparam int BUSY_MAX = 9000;
   int busy_cnt_reg;
   int busy_cnt_next;
   logic go, ok_en, in_rng, ro;
   assign go = ADDR_WRITE && !BUSY;
   assign ok_en = PRODUCT_DATA_FEATURE_ENABLE && EEPROM_PRESENT;
   assign in_rng = EEPROM_SELECT_FIELD != 3'h0 || PRODUCT_DATA_ADDRESS_FIELD <= vpd_pkg::CS0_LIMIT;
   assign ro = PRODUCT_DATA_ADDRESS_FIELD <= vpd_pkg::RO_LIMIT;
   always_comb busy_cnt_next = BUSY ? busy_cnt_reg + 1 : 0;
   always_ff @(posedge CLOCK or negedge RSTN)
      if (!RSTN) busy_cnt_reg <= 0;
      else busy_cnt_reg <= busy_cnt_next;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   AST_OFF_IDLE: assert property (go && !ok_en |=> !BUSY)
      else $error("transfer started while disabled");
   AST_CS0_RANGE: assert property (go && !in_rng |=> !BUSY)
      else $error("out of range address started");
   AST_RO_SKIP: assert property (go && ok_en && in_rng && FLAG_IN && ro |=> !BUSY && !FLAG)
      else $error("read-only write not skipped");
   AST_READ_GO: assert property (go && ok_en && in_rng && !FLAG_IN |=> BUSY && !FLAG)
      else $error("read not started");
   AST_WRITE_GO: assert property (go && ok_en && in_rng && FLAG_IN && !ro |=> BUSY && FLAG)
      else $error("write not started");
   AST_READ_END: assert property ($fell(BUSY) && !$past(FLAG) |-> FLAG)
      else $error("read end without flag set");
   AST_WRITE_END: assert property ($fell(BUSY) && $past(FLAG) |-> !FLAG)
      else $error("write end without flag clear");
   AST_BUSY_LIMIT: assert property (busy_cnt_reg < BUSY_MAX)
      else $error("transfer too long");
   AST_PINS_IDLE: assert property (!BUSY |-> !SCL_OE && !SDA_OE)
      else $error("bus driven while idle");
   cover property ($fell(BUSY) && FLAG);
   cover property ($fell(BUSY) && !FLAG);
   cover property (go && FLAG_IN && ro);
endmodule : vpd_eeprom_access_props

/* File: test/vpd_eeprom_access_test.sv */
/*
   self-checking bench for the product data access block.
   assumes two EEPROM models on one open-drain bus, select 0 and 3.
*/
`timescale 1ns/100ps
module vpd_eeprom_access_test;
   typedef struct {
      logic [2:0] cs;
      logic [7:0] a;
      logic f;
      logic [31:0] d;
      logic ef;
      logic [31:0] ed;
   } vpd_row_t;
   vpd_row_t rows [10];
   logic CLOCK, RSTN, PRODUCT_DATA_FEATURE_ENABLE, EEPROM_PRESENT, ADDR_WRITE, FLAG_IN;
   logic DATA_WRITE, FLAG, BUSY, SCL_IN, SCL_OUT, SCL_OE, SDA_IN, SDA_OUT, SDA_OE, oe_a, oe_b;
   logic [2:0] EEPROM_SELECT_FIELD;
   logic [7:0] PRODUCT_DATA_ADDRESS_FIELD;
   logic [31:0] DATA_IN, PRODUCT_DATA_REGISTER;
   int miscompares = 0;
   int comparisons = 0;
   assign SCL_IN = ~SCL_OE;
   assign SDA_IN = ~(SDA_OE | oe_a | oe_b);
   vpd_eeprom_access vpd_eeprom_access_inst (.*);
   vpd_eeprom_model #(.SEL(3'h0), .SEED(8'h5A)) vpd_eeprom_model_inst (
      .scl(SCL_IN), .sda(SDA_IN), .sda_oe(oe_a));
   vpd_eeprom_model #(.SEL(3'h3), .SEED(8'hC3)) vpd_eeprom_model_inst_b (
      .scl(SCL_IN), .sda(SDA_IN), .sda_oe(oe_b));
   function automatic logic [31:0] pw(input logic [7:0] s, input logic [7:0] b);
      return {(b + 8'h03) ^ s, (b + 8'h02) ^ s, (b + 8'h01) ^ s, b ^ s};
   endfunction : pw
   task automatic wrap_up;
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic [2:0] cs, input logic [7:0] a, input logic f,
         input logic [31:0] d);
      int n = 0;
      @(posedge CLOCK);
      EEPROM_SELECT_FIELD <= cs;
      DATA_IN <= d;
      DATA_WRITE <= f;
      @(posedge CLOCK);
      DATA_WRITE <= 1'b0;
      PRODUCT_DATA_ADDRESS_FIELD <= a;
      FLAG_IN <= f;
      ADDR_WRITE <= 1'b1;
      @(posedge CLOCK);
      ADDR_WRITE <= 1'b0;
      repeat (2) @(posedge CLOCK);
      while (BUSY !== 1'b0 && n < 10000) begin
         @(posedge CLOCK);
         n++;
      end
      if (n >= 10000) begin
         miscompares++;
         wrap_up();
      end
   endtask : xfer
   initial begin
      CLOCK = 1'b0;
      forever #50 CLOCK = ~CLOCK;
   end
   initial begin
      repeat (100000) @(posedge CLOCK);
      miscompares++;
      wrap_up();
   end
   initial begin
      {RSTN, ADDR_WRITE, DATA_WRITE, FLAG_IN, PRODUCT_DATA_ADDRESS_FIELD, DATA_IN} = '0;
      {PRODUCT_DATA_FEATURE_ENABLE, EEPROM_PRESENT} = 2'h3;
      EEPROM_SELECT_FIELD = vpd_pkg::CS_DEFAULT;
      rows[0] = '{3'h0, 8'h00, 1'b0, 32'h0, 1'b1, pw(8'h5A, 8'h40)};
      rows[1] = '{3'h0, 8'hBC, 1'b0, 32'h0, 1'b1, pw(8'h5A, 8'hFC)};
      rows[2] = '{3'h0, 8'hC0, 1'b0, 32'h0, 1'b0, pw(8'h5A, 8'hFC)};
      rows[3] = '{3'h0, 8'h40, 1'b1, 32'h11223344, 1'b0, 32'h11223344};
      rows[4] = '{3'h0, 8'h3C, 1'b1, 32'h55667788, 1'b0, 32'h55667788};
      rows[5] = '{3'h0, 8'h40, 1'b0, 32'h0, 1'b1, 32'h11223344};
      rows[6] = '{3'h0, 8'h3C, 1'b0, 32'h0, 1'b1, pw(8'h5A, 8'h7C)};
      rows[7] = '{3'h3, 8'hFC, 1'b0, 32'h0, 1'b1, pw(8'hC3, 8'hFC)};
      rows[8] = '{3'h3, 8'h42, 1'b1, 32'hA1B2C3D4, 1'b0, 32'hA1B2C3D4};
      rows[9] = '{3'h3, 8'h40, 1'b0, 32'h0, 1'b1, 32'hA1B2C3D4};
      repeat (2) @(posedge CLOCK);
      RSTN <= 1'b1;
      @(posedge CLOCK);
      chk("reset outputs", {26'h0, SCL_OUT, SDA_OUT, FLAG, BUSY, SCL_OE, SDA_OE}, 32'h0);
      chk("reset data", PRODUCT_DATA_REGISTER, 32'h0);
      foreach (rows[i]) begin
         xfer(rows[i].cs, rows[i].a, rows[i].f, rows[i].d);
         chk("flag", {31'h0, FLAG}, {31'h0, rows[i].ef});
         chk("data", PRODUCT_DATA_REGISTER, rows[i].ed);
      end
      for (int k = 0; k < 2; k++) begin
         PRODUCT_DATA_FEATURE_ENABLE <= k[0];
         EEPROM_PRESENT <= ~k[0];
         xfer(3'h3, 8'h00, 1'b0, 32'h0);
         chk("off flag", {31'h0, FLAG}, 32'h0);
         chk("off data", PRODUCT_DATA_REGISTER, 32'hA1B2C3D4);
      end
      EEPROM_PRESENT <= 1'b1;
      fork
         xfer(3'h0, 8'h00, 1'b0, 32'h0);
         begin
            repeat (400) @(posedge CLOCK);
            RSTN <= 1'b0;
         end
      join_any
      @(posedge CLOCK);
      chk("abort outputs", {26'h0, SCL_OUT, SDA_OUT, FLAG, BUSY, SCL_OE, SDA_OE}, 32'h0);
      chk("abort data", PRODUCT_DATA_REGISTER, 32'h0);
      RSTN <= 1'b1;
      xfer(3'h0, 8'h40, 1'b0, 32'h0);
      chk("recovery flag", {31'h0, FLAG}, 32'h1);
      chk("recovery data", PRODUCT_DATA_REGISTER, 32'h11223344);
      wrap_up();
   end
endmodule : vpd_eeprom_access_test
bind vpd_eeprom_access vpd_eeprom_access_props vpd_eeprom_access_props_inst (.*);
